/* sim/pkf_host_model.sv */
// host model: serial bus master doing register writes and reads
// assumes the bench builds the pulled-up sda wire from all enables
`timescale 1ns/1ps
module pkf_host_model (
	input  wire logic i_mclk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	// idle bus, both lines released
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// n quarter periods of five clocks
	task automatic hp(input int n);
		repeat (5 * n) @(posedge i_mclk);
	endtask
	// sda moves mid low phase, never next to an scl edge
	task automatic bt(input logic b, output logic r);
		hp(1);
		o_sda <= b;
		hp(1);
		o_scl <= 1'b1;
		hp(2);
		r = i_sda;
		o_scl <= 1'b0;
	endtask
	// start or repeated start
	task automatic st();
		hp(1);
		o_sda <= 1'b1;
		hp(1);
		o_scl <= 1'b1;
		hp(2);
		o_sda <= 1'b0;
		hp(2);
		o_scl <= 1'b0;
	endtask
	task automatic sp();
		hp(1);
		o_sda <= 1'b0;
		hp(1);
		o_scl <= 1'b1;
		hp(2);
		o_sda <= 1'b1;
		hp(2);
	endtask
	// one byte msb first, then the ninth bit
	task automatic by(input logic [7:0] t, input logic m, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bt(t[i], r[i]);
		end
		bt(m, a);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       k;
		st();
		by({pkf_pkg::I2C_ADDR, 1'b0}, 1'b1, r, k);
		by(a, 1'b1, r, k);
		by(d, 1'b1, r, k);
		sp();
	endtask
	// single byte read ends with a nack
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic       k;
		st();
		by({pkf_pkg::I2C_ADDR, 1'b0}, 1'b1, r, k);
		by(a, 1'b1, r, k);
		st();
		by({pkf_pkg::I2C_ADDR, 1'b1}, 1'b1, r, k);
		by(8'hff, 1'b1, d, k);
		sp();
	endtask
endmodule

/* sim/tb_top.sv */
// bench for the power key and fault sequencer
// assumes the host model on the serial pins and one 200 MHz clock
`timescale 1ns/1ps
module tb_top;
	logic       i_mclk = 1'b0;
	logic       i_sys_rst = 1'b1;
	logic       i_bkup_rst = 1'b1;
	logic       key_n = 1'b1; // hub timing is outside; long press too long here
	logic       i_conv_irq_n = 1'b1;
	logic       i_b_select = 1'b0;
	logic [3:0] flt = 4'h0; // in_uv, over_temp, bat_uv, out_short
	logic       i_scl, sda_h, o_sda_o, o_sda_oe_n, o_power_key_n_o, o_power_key_n_oe_n;
	logic       o_power_good_out, o_rail_en, o_interrupt_request_n;
	logic [1:0] o_core_buck_op, o_mem_buck_op;
	logic [7:0] rd;
	int         num_errors = 0;
	int         n_checks = 0;
	logic [7:0] ra[5] = '{pkf_pkg::REG_MEM_B, pkf_pkg::REG_CORE_B, pkf_pkg::REG_MEM_CFG, pkf_pkg::REG_CORE_CFG, 8'h55};
	logic [7:0] rv[5] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
	int         lb[5] = '{pkf_pkg::LOG_IN_UV, pkf_pkg::LOG_TEMP, pkf_pkg::LOG_BAT_UV, pkf_pkg::LOG_SHORT, 1};
	// open-drain wires with pull-ups
	wire        i_sda = sda_h & (o_sda_oe_n | o_sda_o);
	wire        i_power_key_n = key_n & (o_power_key_n_oe_n | o_power_key_n_o);
	always #2.5 i_mclk = ~i_mclk;
	pkf_host_model host (.i_mclk, .i_sda, .o_scl(i_scl), .o_sda(sda_h));
	pkf_sequencer #(.ARM_MS_P(2), .FCO_MS_P(2)) uut (
		.i_mclk, .i_sys_rst, .i_bkup_rst, .i_scl, .i_sda, .o_sda_o, .o_sda_oe_n,
		.i_power_key_n, .o_power_key_n_o, .o_power_key_n_oe_n, .i_conv_irq_n,
		.i_in_uv(flt[0]), .i_over_temp(flt[1]), .i_bat_uv(flt[2]), .i_out_short(flt[3]),
		.i_b_select, .o_power_good_out, .o_rail_en, .o_interrupt_request_n,
		.o_core_buck_op, .o_mem_buck_op
	);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// expected buck operation: 00 defers to the b selection
	function automatic logic [1:0] op(input logic [1:0] m, input logic s, input logic b);
		return (m != 2'h0) ? m : ((s & b) ? 2'h1 : 2'h2);
	endfunction
	// bounded wait on pg (0) or rail (1)
	task automatic wt(input int w, input logic v, output int n);
		n = 0;
		while ((w ? o_rail_en : o_power_good_out) !== v && n < 3000) begin
			@(posedge i_mclk);
			n++;
		end
		if (n >= 3000) begin
			num_errors++;
			$display("[ERR] %0t wait %h exp %h", $time, w, v);
			conclude();
		end
	endtask
	task automatic sysrst();
		i_sys_rst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		repeat (5) @(posedge i_mclk);
	endtask
	initial begin
		logic [1:0] m;
		logic [1:0] c;
		logic       s;
		logic       b;
		int         n;
		int         d;
		void'($urandom(28112));
		repeat (12) @(posedge i_mclk);
		i_bkup_rst <= 1'b0;
		sysrst();
		chk(o_power_good_out & o_rail_en & o_interrupt_request_n, 8'h01);
		foreach (ra[i]) begin
			host.rd(ra[i], rd);
			chk(rd, rv[i]);
		end
		i_conv_irq_n <= 1'b0;
		repeat (6) @(posedge i_mclk);
		chk(o_interrupt_request_n, 8'h00);
		i_conv_irq_n <= 1'b1;
		repeat (6) @(posedge i_mclk);
		chk(o_interrupt_request_n, 8'h01);
		$display("test regs irq done");
		// all mem modes and sleep bits, random core mode and b select
		for (int i = 0; i < 8; i++) begin
			m = i[1:0];
			s = i[2];
			{c, b} = 3'($urandom);
			i_b_select <= b | (i == 4);
			host.wr(pkf_pkg::REG_MEM_CFG, {m, 6'h00});
			host.wr(pkf_pkg::REG_MEM_B, {s, 7'h15});
			host.wr(pkf_pkg::REG_CORE_CFG, {c, 6'h00});
			host.wr(pkf_pkg::REG_CORE_B, {s, 7'h0a});
			repeat (6) @(posedge i_mclk);
			chk(o_mem_buck_op, op(m, s, i_b_select));
			chk(o_core_buck_op, op(c, s, i_b_select));
		end
		host.rd(pkf_pkg::REG_MEM_CFG, rd);
		chk(rd, {m, 6'h00});
		$display("test modes done");
		// faults, soft reset, cold off; log must outlive a system reset
		for (int k = 0; k < 6; k++) begin
			if (k < 4)
				flt[k] <= 1'b1;
			else
				host.wr(pkf_pkg::REG_CTRL, (k == 4) ? 8'h01 : 8'h02);
			wt(0, 1'b0, n);
			d = (k == 2 || k == 3) ? 0 : 10 * pkf_pkg::US_CYC;
			if (k == 5) begin
				repeat (3000) @(posedge i_mclk);
				chk(o_rail_en, 8'h01);
			end else begin
				wt(1, 1'b0, n);
				chk(n + pkf_pkg::US_CYC + 100 >= d && n <= ((d != 0) ? d + pkf_pkg::US_CYC + 10 : 2), 8'h01);
				chk(o_power_good_out, 8'h00);
			end
			flt <= 4'h0;
			sysrst();
			host.rd(pkf_pkg::REG_LOG, rd);
			if (k < 5)
				chk(rd, 8'(1 << lb[k]));
			host.wr(pkf_pkg::REG_LOG, 8'hff);
			$display("test fault %0d done", k);
		end
		host.wr(pkf_pkg::REG_FAULT, 8'h03);
		host.rd(pkf_pkg::REG_FAULT, rd);
		chk(rd, 8'h00);
		// shelf, then a key press wakes the chain
		host.wr(pkf_pkg::REG_CTRL, 8'h04);
		wt(1, 1'b0, n);
		chk(o_power_good_out, 8'h00);
		key_n <= 1'b0;
		repeat (8) @(posedge i_mclk);
		key_n <= 1'b1;
		chk(o_power_key_n_oe_n, 8'h00);
		wt(0, 1'b1, n);
		chk(o_power_key_n_oe_n & o_rail_en, 8'h01);
		$display("test shelf done");
		conclude();
	end
endmodule

/* src/pkf_i2c_slave.sv */
// serial register port: address byte, register pointer, data bytes
// assumes scl and sda arrive from pins; pointer auto-increments
`timescale 1ns/1ps
module pkf_i2c_slave (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	// pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_o,
	output logic            o_sda_oe_n,
	// register side
	output logic            o_wr_stb,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_wdata,
	input  wire logic [7:0] i_rdata
);
	logic [1:0] s1_q, s2_q, s3_q;  // {scl,sda} sync and history
	pkf_pkg::pkf_i2c_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d;      // bit counter
	logic [7:0] sh_q, sh_d;        // shift register
	logic [7:0] ptr_q, ptr_d;      // register pointer
	logic       rw_q, rw_d;        // read request
	logic       oen_q, oen_d;      // low while pulling sda
	logic       wr_q, wr_d;
	logic       rise, fall, start, stop;

	// two flops before use, third only for edges
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_q <= 2'h3;
			s2_q <= 2'h3;
			s3_q <= 2'h3;
		end else begin
			s1_q <= {i_scl, i_sda};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	assign rise  = s2_q[1] & ~s3_q[1];
	assign fall  = ~s2_q[1] & s3_q[1];
	assign start = s2_q[1] & s3_q[1] & ~s2_q[0] & s3_q[0];
	assign stop  = s2_q[1] & s3_q[1] & s2_q[0] & ~s3_q[0];

	// protocol next state
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		oen_d = oen_q;
		wr_d = 1'b0;
		if (start) begin
			st_d = pkf_pkg::I_ADDR;
			cnt_d = 4'h0;
			oen_d = 1'b1;
		end else if (stop) begin
			st_d = pkf_pkg::I_IDLE;
			oen_d = 1'b1;
		end else if (rise) begin
			// data sampled while scl high
			if (st_q == pkf_pkg::I_ADDR || st_q == pkf_pkg::I_REG || st_q == pkf_pkg::I_WDAT) begin
				sh_d = {sh_q[6:0], s2_q[0]};
				cnt_d = cnt_q + 4'h1;
			end else if (st_q == pkf_pkg::I_MACK) begin
				// master nack ends the read burst
				if (s2_q[0])
					st_d = pkf_pkg::I_IDLE;
				else
					ptr_d = ptr_q + 8'h01;
			end
		end else if (fall) begin
			unique case (st_q)
				pkf_pkg::I_ADDR, pkf_pkg::I_REG, pkf_pkg::I_WDAT: begin
					if (cnt_q == 4'h8) begin
						cnt_d = 4'h0;
						oen_d = 1'b0;
						if (st_q == pkf_pkg::I_ADDR) begin
							rw_d = sh_q[0];
							st_d = pkf_pkg::I_AACK;
							// other addresses are left alone
							if (sh_q[7:1] != pkf_pkg::I2C_ADDR) begin
								oen_d = 1'b1;
								st_d = pkf_pkg::I_IDLE;
							end
						end else if (st_q == pkf_pkg::I_REG) begin
							ptr_d = sh_q;
							st_d = pkf_pkg::I_RACK;
						end else begin
							wr_d = 1'b1;
							st_d = pkf_pkg::I_WACK;
						end
					end
				end
				pkf_pkg::I_AACK, pkf_pkg::I_MACK: begin
					if (rw_q) begin
						sh_d = i_rdata;
						oen_d = i_rdata[7];
						cnt_d = 4'h1;
						st_d = pkf_pkg::I_RDAT;
					end else begin
						oen_d = 1'b1;
						st_d = pkf_pkg::I_REG;
					end
				end
				pkf_pkg::I_RACK: begin
					oen_d = 1'b1;
					st_d = pkf_pkg::I_WDAT;
				end
				pkf_pkg::I_WACK: begin
					oen_d = 1'b1;
					ptr_d = ptr_q + 8'h01;
					st_d = pkf_pkg::I_WDAT;
				end
				pkf_pkg::I_RDAT: begin
					if (cnt_q == 4'h8) begin
						oen_d = 1'b1;
						cnt_d = 4'h0;
						st_d = pkf_pkg::I_MACK;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						oen_d = sh_q[6];
						cnt_d = cnt_q + 4'h1;
					end
				end
				default: ;
			endcase
		end
	end

	// protocol registers
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= pkf_pkg::I_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			oen_q <= 1'b1;
			wr_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			oen_q <= oen_d;
			wr_q <= wr_d;
		end
	end

	assign o_sda_o    = 1'b0;
	assign o_sda_oe_n = oen_q;
	assign o_wr_stb   = wr_q;
	assign o_addr     = ptr_q;
	assign o_wdata    = sh_q;
endmodule

/* src/pkf_pkg.sv */
// shared constants for the power key and fault sequencer
// assumes a single 200 MHz clock; all times derive from it
package pkf_pkg;
	// register offsets on the serial bus
	localparam logic [7:0] REG_CTRL     = 8'h10; // command strobes, read zero
	localparam logic [7:0] REG_FAULT    = 8'h11; // event flags, write one to clear
	localparam logic [7:0] REG_LOG      = 8'h12; // fault cause log, write one to clear
	localparam logic [7:0] REG_KEY_DLY  = 8'h13; // key press delay, ms
	localparam logic [7:0] REG_SHUT_DLY = 8'h14; // shutdown press delay, ms
	localparam logic [7:0] REG_PG_DLY   = 8'h15; // power good lead, us
	localparam logic [7:0] REG_FLT_TIME = 8'h16; // fault recovery time, ms
	localparam logic [7:0] REG_STATUS   = 8'h17; // sequencer state, read only
	localparam logic [7:0] REG_CORE_CFG = 8'ha0; // core buck mode
	localparam logic [7:0] REG_MEM_CFG  = 8'ha1; // memory buck mode
	localparam logic [7:0] REG_CORE_B   = 8'hb6; // core buck b setting
	localparam logic [7:0] REG_MEM_B    = 8'hb7; // memory buck b setting
	// field positions
	localparam int MODE_LO   = 6; // mode select in bits 7:6
	localparam int SL_B_BIT  = 7; // sleep on b
	localparam int CTRL_SWRST = 0;
	localparam int CTRL_FCO   = 1;
	localparam int CTRL_SHELF = 2;
	localparam int FLT_KEY    = 0; // key reset event
	localparam int FLT_RECOV  = 1; // recovered with cause logged
	localparam int LOG_KEY    = 0;
	localparam int LOG_SWRST  = 1;
	localparam int LOG_IN_UV  = 2;
	localparam int LOG_TEMP   = 3;
	localparam int LOG_BAT_UV = 4;
	localparam int LOG_SHORT  = 5;
	localparam int LOG_FCO    = 6;
	// reset values
	localparam logic [7:0] CFG_RST      = 8'h00;
	localparam logic [7:0] B_RST        = 8'h80; // sleep on b set
	localparam logic [7:0] KEY_DLY_RST  = 8'h64;
	localparam logic [7:0] SHUT_DLY_RST = 8'hc8;
	localparam logic [7:0] PG_DLY_RST   = 8'h0a; // 10 us
	localparam logic [7:0] FLT_TIME_RST = 8'h14;
	localparam logic [7:0] KEY_PULSE_US = 8'h0a; // shelf wake pulse
	// timing
	localparam int CLK_NS   = 5;
	localparam int US_NS    = 1000;
	localparam int US_CYC   = (US_NS + CLK_NS - 1) / CLK_NS;
	localparam int MS_US    = 1000;
	localparam int ARM_S    = 1; // host abort window
	localparam int FCO_S    = 1; // power good lead on cold off
	localparam int ARM_MS   = ARM_S * 1000;
	localparam int FCO_MS   = FCO_S * 1000;
	localparam logic [6:0] I2C_ADDR = 7'h58; // bus address, free to change
	// buck operation modes
	typedef enum logic [1:0] {
		MODE_AB = 2'h0, MODE_SLEEP = 2'h1, MODE_SYNC = 2'h2, MODE_AUTO = 2'h3
	} pkf_mode_t;
	// sequencer states
	typedef enum logic [2:0] {
		ST_ON = 3'h0, ST_ARMED = 3'h1, ST_PG_LOW = 3'h3, ST_OFF = 3'h2,
		ST_SHELF = 3'h6, ST_WAKE = 3'h7, ST_FCO = 3'h5
	} pkf_state_t;
	// serial slave states
	typedef enum logic [3:0] {
		I_IDLE = 4'h0, I_ADDR = 4'h1, I_AACK = 4'h3, I_REG = 4'h2, I_RACK = 4'h6,
		I_WDAT = 4'h7, I_WACK = 4'h5, I_RDAT = 4'h4, I_MACK = 4'hc
	} pkf_i2c_t;
endpackage

/* src/pkf_sequencer.sv */
// power key, fault and buck mode sequencer, top level
// assumes host on the serial bus, monitor inputs from analog blocks
`timescale 1ns/1ps
module pkf_sequencer #(
	parameter int ARM_MS_P = pkf_pkg::ARM_MS, // abort window, ms
	parameter int FCO_MS_P = pkf_pkg::FCO_MS  // cold off lead, ms
) (
	// clock and resets
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_bkup_rst,
	// serial bus pins
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	output logic            o_sda_o,
	output logic            o_sda_oe_n,
	// power key, open drain
	input  wire logic       i_power_key_n,
	output logic            o_power_key_n_o,
	output logic            o_power_key_n_oe_n,
	// monitors and platform inputs
	input  wire logic       i_conv_irq_n,
	input  wire logic       i_in_uv,
	input  wire logic       i_over_temp,
	input  wire logic       i_bat_uv,
	input  wire logic       i_out_short,
	input  wire logic       i_b_select,
	// power control outputs
	output logic            o_power_good_out,
	output logic            o_rail_en,
	output logic            o_interrupt_request_n,
	output logic [1:0]      o_core_buck_op,
	output logic [1:0]      o_mem_buck_op
);
	localparam logic [6:0] SYNC_RST = 7'h41; // key and irq idle high
	logic [6:0] sy1_q, sy2_q;             // input synchroniser
	logic key_n_s, in_uv_s, temp_s, bat_uv_s, short_s, bsel_s, irq_n_s;
	logic [7:0] us_cnt_q, us_cnt_d;       // microsecond divider
	logic [9:0] ms_cnt_q, ms_cnt_d;       // millisecond divider
	logic us_tick, ms_tick;
	logic wr;                             // bus write strobe
	logic [7:0] addr, wdata, rdata;
	logic [7:0] core_cfg_q, mem_cfg_q, core_b_q, mem_b_q;
	logic [7:0] key_dly_q, shut_dly_q, pg_dly_q, flt_time_q;
	logic [7:0] core_cfg_d, mem_cfg_d, core_b_d, mem_b_d;
	logic [7:0] key_dly_d, shut_dly_d, pg_dly_d, flt_time_d;
	logic swrst_cmd, fco_cmd, shelf_cmd;  // command strobes
	logic key_flag_q, key_flag_d, recov_q, recov_d;
	logic [6:0] log_q, log_d, log_set;    // backup domain cause log
	logic [8:0] key_cnt_q, key_cnt_d;     // press length, ms
	logic long_press, hard, done, set_key, set_recov;
	pkf_pkg::pkf_state_t st_q, st_d;
	logic [9:0] tmr_q, tmr_d;
	logic rail_q, rail_d, pg_q, pg_d, key_oe_n_q, key_oe_n_d;
	logic irq_n_q, irq_n_d;
	logic [1:0] core_op_q, core_op_d, mem_op_q, mem_op_d;

	// buck operation from mode field, b select and sleep bit
	function automatic logic [1:0] buck_op(input logic [7:0] cfg, input logic [7:0] b, input logic bsel);
		logic [1:0] m;
		m = cfg[pkf_pkg::MODE_LO +: 2];
		// mode 00 defers to b setting
		if (m == pkf_pkg::MODE_AB)
			buck_op = (bsel && b[pkf_pkg::SL_B_BIT]) ? pkf_pkg::MODE_SLEEP : pkf_pkg::MODE_SYNC;
		else
			buck_op = m;
	endfunction

	pkf_i2c_slave u_bus (
		.i_mclk     (i_mclk),
		.i_sys_rst  (i_sys_rst),
		.i_scl      (i_scl),
		.i_sda      (i_sda),
		.o_sda_o    (o_sda_o),
		.o_sda_oe_n (o_sda_oe_n),
		.o_wr_stb   (wr),
		.o_addr     (addr),
		.o_wdata    (wdata),
		.i_rdata    (rdata)
	);

	// pins cross into the clock through two flops
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sy1_q <= SYNC_RST;
			sy2_q <= SYNC_RST;
		end else begin
			sy1_q <= {i_conv_irq_n, i_b_select, i_out_short, i_bat_uv, i_over_temp, i_in_uv, i_power_key_n};
			sy2_q <= sy1_q;
		end
	end
	assign {irq_n_s, bsel_s, short_s, bat_uv_s, temp_s, in_uv_s, key_n_s} = sy2_q;

	// tick dividers
	always_comb begin
		us_tick = (us_cnt_q == 8'(pkf_pkg::US_CYC - 1));
		ms_tick = us_tick && (ms_cnt_q == 10'(pkf_pkg::MS_US - 1));
		us_cnt_d = us_tick ? 8'h00 : us_cnt_q + 8'h01;
		ms_cnt_d = ms_cnt_q;
		if (us_tick)
			ms_cnt_d = ms_tick ? 10'h000 : ms_cnt_q + 10'h001;
	end
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			us_cnt_q <= 8'h00;
			ms_cnt_q <= 10'h000;
		end else begin
			us_cnt_q <= us_cnt_d;
			ms_cnt_q <= ms_cnt_d;
		end
	end

	// register writes and command strobes
	always_comb begin
		core_cfg_d = core_cfg_q;
		mem_cfg_d = mem_cfg_q;
		core_b_d = core_b_q;
		mem_b_d = mem_b_q;
		key_dly_d = key_dly_q;
		shut_dly_d = shut_dly_q;
		pg_dly_d = pg_dly_q;
		flt_time_d = flt_time_q;
		if (wr) begin
			unique case (addr)
				pkf_pkg::REG_CORE_CFG: core_cfg_d = wdata;
				pkf_pkg::REG_MEM_CFG: mem_cfg_d = wdata;
				pkf_pkg::REG_CORE_B: core_b_d = wdata;
				pkf_pkg::REG_MEM_B: mem_b_d = wdata;
				pkf_pkg::REG_KEY_DLY: key_dly_d = wdata;
				pkf_pkg::REG_SHUT_DLY: shut_dly_d = wdata;
				pkf_pkg::REG_PG_DLY: pg_dly_d = wdata;
				pkf_pkg::REG_FLT_TIME: flt_time_d = wdata;
				default: ;
			endcase
		end
	end
	assign swrst_cmd = wr && addr == pkf_pkg::REG_CTRL && wdata[pkf_pkg::CTRL_SWRST];
	assign fco_cmd   = wr && addr == pkf_pkg::REG_CTRL && wdata[pkf_pkg::CTRL_FCO];
	assign shelf_cmd = wr && addr == pkf_pkg::REG_CTRL && wdata[pkf_pkg::CTRL_SHELF];
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			core_cfg_q <= pkf_pkg::CFG_RST;
			mem_cfg_q <= pkf_pkg::CFG_RST;
			core_b_q <= pkf_pkg::B_RST;
			// sleep on b resets to one
			mem_b_q <= pkf_pkg::B_RST;
			key_dly_q <= pkf_pkg::KEY_DLY_RST;
			shut_dly_q <= pkf_pkg::SHUT_DLY_RST;
			pg_dly_q <= pkf_pkg::PG_DLY_RST;
			flt_time_q <= pkf_pkg::FLT_TIME_RST;
		end else begin
			core_cfg_q <= core_cfg_d;
			mem_cfg_q <= mem_cfg_d;
			core_b_q <= core_b_d;
			mem_b_q <= mem_b_d;
			key_dly_q <= key_dly_d;
			shut_dly_q <= shut_dly_d;
			pg_dly_q <= pg_dly_d;
			flt_time_q <= flt_time_d;
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		unique case (addr)
			pkf_pkg::REG_CORE_CFG: rdata = core_cfg_q;
			pkf_pkg::REG_MEM_CFG: rdata = mem_cfg_q;
			pkf_pkg::REG_CORE_B: rdata = core_b_q;
			pkf_pkg::REG_MEM_B: rdata = mem_b_q;
			pkf_pkg::REG_KEY_DLY: rdata = key_dly_q;
			pkf_pkg::REG_SHUT_DLY: rdata = shut_dly_q;
			pkf_pkg::REG_PG_DLY: rdata = pg_dly_q;
			pkf_pkg::REG_FLT_TIME: rdata = flt_time_q;
			pkf_pkg::REG_FAULT: rdata = {6'h00, recov_q, key_flag_q};
			pkf_pkg::REG_LOG: rdata = {1'b0, log_q};
			pkf_pkg::REG_STATUS: rdata = {3'h0, st_q, rail_q, pg_q};
			default: rdata = 8'h00;
		endcase
	end

	// press length counts only while key held
	always_comb begin
		key_cnt_d = key_cnt_q;
		if (key_n_s || st_q != pkf_pkg::ST_ON)
			key_cnt_d = 9'h000;
		else if (ms_tick && key_cnt_q != 9'h1ff)
			key_cnt_d = key_cnt_q + 9'h001;
	end
	assign long_press = key_cnt_q > ({1'b0, key_dly_q} + {1'b0, shut_dly_q});
	assign hard = rail_q && (bat_uv_s || short_s);
	assign done = (tmr_q == 10'h000);

	// power sequencing
	always_comb begin
		st_d = st_q;
		tmr_d = tmr_q;
		rail_d = rail_q;
		pg_d = pg_q;
		key_oe_n_d = key_oe_n_q;
		set_key = 1'b0;
		set_recov = 1'b0;
		log_set = 7'h00;
		if (hard) begin
			st_d = pkf_pkg::ST_OFF;
			rail_d = 1'b0;
			pg_d = 1'b0;
			key_oe_n_d = 1'b1;
			tmr_d = {2'h0, flt_time_q};
			log_set[pkf_pkg::LOG_BAT_UV] = bat_uv_s;
			log_set[pkf_pkg::LOG_SHORT] = short_s;
		end else begin
			unique case (st_q)
				pkf_pkg::ST_ON: begin
					if (swrst_cmd || in_uv_s || temp_s) begin
						pg_d = 1'b0;
						tmr_d = {2'h0, pg_dly_q};
						st_d = pkf_pkg::ST_PG_LOW;
						log_set[pkf_pkg::LOG_SWRST] = swrst_cmd;
						log_set[pkf_pkg::LOG_IN_UV] = in_uv_s;
						log_set[pkf_pkg::LOG_TEMP] = temp_s;
					end else if (fco_cmd) begin
						pg_d = 1'b0;
						tmr_d = 10'(FCO_MS_P);
						st_d = pkf_pkg::ST_FCO;
						log_set[pkf_pkg::LOG_FCO] = 1'b1;
					end else if (shelf_cmd) begin
						rail_d = 1'b0;
						pg_d = 1'b0;
						st_d = pkf_pkg::ST_SHELF;
					end else if (long_press) begin
						// flag and arm, rail stays up
						set_key = 1'b1;
						tmr_d = 10'(ARM_MS_P);
						st_d = pkf_pkg::ST_ARMED;
					end
				end
				pkf_pkg::ST_ARMED: begin
					if (!key_flag_q)
						st_d = pkf_pkg::ST_ON;
					else if (ms_tick) begin
						tmr_d = tmr_q - 10'h001;
						if (done) begin
							pg_d = 1'b0;
							tmr_d = {2'h0, pg_dly_q};
							st_d = pkf_pkg::ST_PG_LOW;
							log_set[pkf_pkg::LOG_KEY] = 1'b1;
						end
					end
				end
				pkf_pkg::ST_PG_LOW: begin
					if (us_tick) begin
						tmr_d = tmr_q - 10'h001;
						if (done) begin
							rail_d = 1'b0;
							tmr_d = {2'h0, flt_time_q};
							st_d = pkf_pkg::ST_OFF;
						end
					end
				end
				pkf_pkg::ST_OFF: begin
					if (ms_tick) begin
						tmr_d = tmr_q - 10'h001;
						if (done) begin
							rail_d = 1'b1;
							pg_d = 1'b1;
							set_recov = |log_q;
							st_d = pkf_pkg::ST_ON;
						end
					end
				end
				pkf_pkg::ST_FCO: begin
					if (ms_tick) begin
						tmr_d = tmr_q - 10'h001;
						if (done) begin
							rail_d = 1'b0;
							st_d = pkf_pkg::ST_SHELF;
						end
					end
				end
				pkf_pkg::ST_SHELF: begin
					// key press wakes, pull key for the chain
					if (!key_n_s) begin
						rail_d = 1'b1;
						key_oe_n_d = 1'b0;
						tmr_d = {2'h0, pkf_pkg::KEY_PULSE_US};
						st_d = pkf_pkg::ST_WAKE;
					end
				end
				pkf_pkg::ST_WAKE: begin
					if (us_tick) begin
						tmr_d = tmr_q - 10'h001;
						if (done) begin
							key_oe_n_d = 1'b1;
							pg_d = 1'b1;
							st_d = pkf_pkg::ST_ON;
						end
					end
				end
				default: st_d = pkf_pkg::ST_OFF;
			endcase
		end
	end

	// flags: a set in the clearing cycle wins
	always_comb begin
		key_flag_d = set_key | (key_flag_q & ~(wr && addr == pkf_pkg::REG_FAULT && wdata[pkf_pkg::FLT_KEY]));
		recov_d = set_recov | (recov_q & ~(wr && addr == pkf_pkg::REG_FAULT && wdata[pkf_pkg::FLT_RECOV]));
		log_d = log_set | (log_q & ~((wr && addr == pkf_pkg::REG_LOG) ? wdata[6:0] : 7'h00));
		irq_n_d = ~(key_flag_q | recov_q | ~irq_n_s);
		core_op_d = buck_op(core_cfg_q, core_b_q, bsel_s);
		mem_op_d = buck_op(mem_cfg_q, mem_b_q, bsel_s);
	end

	// main domain state
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= pkf_pkg::ST_ON;
			tmr_q <= 10'h000;
			rail_q <= 1'b1;
			pg_q <= 1'b1;
			key_oe_n_q <= 1'b1;
			key_cnt_q <= 9'h000;
			key_flag_q <= 1'b0;
			recov_q <= 1'b0;
			irq_n_q <= 1'b1;
			core_op_q <= pkf_pkg::MODE_SYNC;
			mem_op_q <= pkf_pkg::MODE_SYNC;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			rail_q <= rail_d;
			pg_q <= pg_d;
			key_oe_n_q <= key_oe_n_d;
			key_cnt_q <= key_cnt_d;
			key_flag_q <= key_flag_d;
			recov_q <= recov_d;
			irq_n_q <= irq_n_d;
			core_op_q <= core_op_d;
			mem_op_q <= mem_op_d;
		end
	end

	// cause log lives on the backup supply reset only
	always_ff @(posedge i_mclk or posedge i_bkup_rst) begin
		if (i_bkup_rst)
			log_q <= 7'h00;
		else
			log_q <= log_d;
	end

	assign o_power_good_out      = pg_q;
	assign o_rail_en             = rail_q;
	assign o_power_key_n_o       = 1'b0;
	assign o_power_key_n_oe_n    = key_oe_n_q;
	assign o_interrupt_request_n = irq_n_q;
	assign o_core_buck_op        = core_op_q;
	assign o_mem_buck_op         = mem_op_q;

	AST_SWRST_PG: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(st_q == pkf_pkg::ST_ON && swrst_cmd && !hard) |=> !o_power_good_out && o_rail_en)
		else $error("software reset did not drop power good first");
	AST_LONG_ARM: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(st_q == pkf_pkg::ST_ON && long_press && !hard && !swrst_cmd && !in_uv_s && !temp_s && !fco_cmd && !shelf_cmd)
		|=> key_flag_q ##1 !o_interrupt_request_n)
		else $error("long press did not flag and interrupt");
	AST_NO_EARLY_ARM: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$rose(key_flag_q) |-> $past(long_press) && $past(st_q) == pkf_pkg::ST_ON)
		else $error("armed without a long press");
	AST_ABORT: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(st_q == pkf_pkg::ST_ARMED && !key_flag_q && !hard) |=> st_q == pkf_pkg::ST_ON && o_power_good_out)
		else $error("cleared event did not abort reset");
	AST_PG_LEADS_RAIL: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		($fell(o_rail_en) && !$past(hard) && $past(st_q) != pkf_pkg::ST_ON) |-> !$past(o_power_good_out))
		else $error("rail dropped before power good");
	AST_HARD_CUT: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		hard |=> !o_rail_en && (log_q[pkf_pkg::LOG_BAT_UV] || log_q[pkf_pkg::LOG_SHORT]))
		else $error("hard fault did not cut and log");
	AST_TEMP_LOG: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(st_q == pkf_pkg::ST_ON && temp_s && !hard) |=> log_q[pkf_pkg::LOG_TEMP] && st_q == pkf_pkg::ST_PG_LOW)
		else $error("overtemp not logged");
	AST_OFF_HOLD: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		$rose(o_rail_en) |-> $past(st_q) == pkf_pkg::ST_OFF && $past(done) || $past(st_q) == pkf_pkg::ST_SHELF)
		else $error("power up before recovery time");
	AST_MEM_MODE: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		(mem_cfg_q[7:6] == 2'h2) |=> o_mem_buck_op == pkf_pkg::MODE_SYNC)
		else $error("forced sync mode not applied");
	AST_IRQ_PASS: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
		!irq_n_s |=> !o_interrupt_request_n)
		else $error("converter interrupt not forwarded");
endmodule
